/* File: dv/flush_responder.sv */
// lookup engine model that accepts table flush requests
`timescale 1ns/10ps
`default_nettype none
module flush_responder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic flush_valid,
	output logic flush_ready
);
	logic [2:0] wait_q;
	logic slow_q;
	// alternate a short and a long wait so the held request is seen across a busy write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 3'h0;
			flush_ready <= 1'b0;
			slow_q <= 1'b0;
		end else if (flush_valid && !flush_ready) begin
			wait_q <= wait_q + 3'h1;
			flush_ready <= (wait_q == (slow_q ? 3'h6 : 3'h3));
		end else begin
			wait_q <= 3'h0;
			flush_ready <= 1'b0;
			slow_q <= slow_q ^ flush_ready;
		end
	end
endmodule
`default_nettype wire

/* File: dv/stp_gate_checker.sv */
// concurrent checks on the ports of the spanning tree gating block
`timescale 1ns/10ps
`default_nettype none
module stp_gate_checker
	import stp_gate_pkg::*;
#(
	parameter int NUM_PORTS = 7
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dec_valid,
	input wire logic [2:0] dec_src_port,
	input wire logic [NUM_PORTS-1:0] dec_dst_mask,
	input wire logic [NUM_PORTS-1:0] dec_tag_mask,
	input wire logic res_valid,
	input wire logic [NUM_PORTS-1:0] res_mask,
	input wire logic res_learn,
	input wire logic flush_valid,
	input wire logic flush_ready,
	input wire logic [NUM_PORTS-1:0] flush_mask
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------------------------------
	// flush handshake steps
	// ----------------------------------------------------------------
	sequence s_flush_wait;
		flush_valid && !flush_ready;
	endsequence
	sequence s_flush_done;
		flush_valid && flush_ready;
	endsequence
	a_res_latency: assert property (dec_valid |=> res_valid) else $error("result late");
	a_res_cause: assert property (res_valid |-> $past(dec_valid)) else $error("stray result");
	a_ingress_clear: assert property (dec_valid |=> ((res_mask >> $past(dec_src_port)) & 1) == 0)
		else $error("ingress port in mask");
	a_bad_src: assert property (dec_valid && dec_src_port >= NUM_PORTS |=> res_mask == '0 && !res_learn)
		else $error("invalid source forwarded");
	a_mask_bound: assert property (dec_valid |=> (res_mask & ~($past(dec_dst_mask) | $past(dec_tag_mask))) == '0)
		else $error("mask outside request");
	a_apb_ready: assert property (psel && penable |-> pready) else $error("wait state seen");
	a_unmapped_err: assert property (psel && penable && paddr >= 8'h48 |-> pslverr)
		else $error("no error on unmapped");
	a_flush_hold: assert property (s_flush_wait |=> flush_valid && $stable(flush_mask))
		else $error("flush request dropped");
	a_flush_end: assert property (s_flush_done |=> !flush_valid) else $error("flush not released");
	a_flush_mask: assert property (flush_valid |-> flush_mask != '0) else $error("empty flush");
endmodule
bind stp_state_gating stp_gate_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.pclk, .presetn, .psel,
	.penable, .paddr, .pready, .pslverr, .dec_valid, .dec_src_port, .dec_dst_mask, .dec_tag_mask,
	.res_valid, .res_mask, .res_learn, .flush_valid, .flush_ready, .flush_mask);
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the spanning tree gating block
`timescale 1ns/10ps
`default_nettype none
module testbench
	import stp_gate_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rng, r;
	logic dec_valid, dec_override_hit, dec_tag_lookup, dec_tag_block_override, res_valid, res_learn;
	logic [2:0] dec_src_port;
	logic [6:0] dec_dst_mask, dec_tag_mask, res_mask, flush_mask;
	logic flush_valid, flush_ready, flush_dynamic, flush_static;
	logic [3:0] ctrl [7];
	logic [7:0] exp_q [$];
	int errors, checks;
	stp_state_gating #(.NUM_PORTS(7)) uut (.*);
	flush_responder u_peer (.*);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// ----------------------------------------------------------------
	// expected forwarding result
	// ----------------------------------------------------------------
	function automatic logic [7:0] expect_res(input logic [2:0] s, input logic [6:0] dst,
		input logic ovr, input logic lk, input logic bo, input logic [6:0] tm);
		logic [6:0] hb, tx, mk;
		int n;
		n = 0;
		hb = 7'h00;
		for (int p = 0; p < 7; p++) if (ctrl[p][3]) n++;
		for (int p = 0; p < 7; p++) hb[p] = ctrl[p][3] && n == 1;
		for (int p = 0; p < 7; p++) tx[p] = ctrl[p][0] | hb[p];
		if (s > 3'h6) return 8'h00;
		if (hb[s]) mk = lk ? dst & tx : (bo ? tm : tm & tx);
		else if (ctrl[s][1]) mk = dst & tx;
		else if (ovr) mk = dst & hb;
		else mk = 7'h00;
		return {hb[s] | !ctrl[s][2], mk & ~(7'h01 << s)};
	endfunction
	always @(negedge pclk) begin
		if (res_valid === 1'b1) begin
			if (exp_q.size() == 0) check(32'h0, 32'h1);
			else check(32'({res_learn, res_mask}), 32'(exp_q.pop_front()));
		end
	end
	task automatic run_round(input int rd);
		logic [3:0] c;
		logic [31:0] d;
		logic [6:0] inh, fm;
		int tails;
		inh = 7'h00;
		tails = 0;
		for (int p = 0; p < 7; p++) begin
			rng = xs(rng);
			c = (rng[1:0] == 2'h0) ? 4'h3 : (rng[1:0] == 2'h1) ? 4'h4 : 4'(rng[4:2] & {3{rng[0]}});
			c[3] = (p == (rd == 1 ? 7 : 2 * rd)) || (rd == 3 && p == 1);
			ctrl[p] = c;
			inh[p] = c[2];
			tails += c[3];
			apb(1'b1, PORT_CTRL_BASE + 8'(4 * p), 32'(c));
			apb(1'b0, PORT_CTRL_BASE + 8'(4 * p), 32'h0);
			check(32'(r[3:0]), 32'(c));
			if (!c[3]) check(32'(r[5:4]), c[2:0] == 3'b100 ? 32'h0 : c[2:0] == 3'b000 ? 32'h1 :
				c[2:0] == 3'b011 ? 32'h2 : 32'h3);
		end
		apb(1'b0, STATUS_OFS, 32'h0);
		check(32'({r[12], r[8], r[6:0]}), 32'({tails > 1, tails == 1, inh}));
		for (int i = 0; i < 24; i++) begin
			rng = xs(rng);
			dec_valid <= 1'b1;
			dec_src_port <= rng[2:0];
			dec_dst_mask <= rng[9:3];
			dec_override_hit <= rng[10];
			dec_tag_lookup <= rng[11];
			dec_tag_block_override <= rng[12];
			dec_tag_mask <= rng[19:13];
			exp_q.push_back(expect_res(rng[2:0], rng[9:3], rng[10], rng[11], rng[12], rng[19:13]));
			@(posedge pclk);
		end
		dec_valid <= 1'b0;
		@(posedge pclk);
		rng = xs(rng);
		d = {14'h0, rng[17:16], 9'h0, rng[6:0]};
		fm = rng[6:0] & inh;
		apb(1'b1, FLUSH_OFS, d);
		if (fm != 7'h00) begin
			for (int i = 0; i < 8 && flush_valid !== 1'b1; i++) @(posedge pclk);
			check(32'({flush_valid, flush_static, flush_dynamic, flush_mask}), 32'({1'b1, d[17:16], fm}));
			apb(1'b1, FLUSH_OFS, ~d);
			check(32'(flush_mask), 32'(fm));
			for (int i = 0; i < 16 && flush_valid !== 1'b0; i++) @(posedge pclk);
			check(32'(flush_valid), 32'h0);
		end else begin
			repeat (2) @(posedge pclk);
			check(32'(flush_valid), 32'h0);
		end
	endtask
	initial begin
		errors = 0;
		checks = 0;
		rng = 32'h0001_3F3A;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{dec_valid, dec_src_port, dec_dst_mask, dec_override_hit} = '0;
		{dec_tag_lookup, dec_tag_block_override, dec_tag_mask} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, PORT_CTRL_BASE, 32'h0);
		check(r, 32'h0000_0023);
		apb(1'b0, 8'h80, 32'h0);
		check({r[30:0], e}, 32'h0000_0001);
		for (int rd = 0; rd < 4; rd++) run_round(rd);
		repeat (4) @(posedge pclk);
		report_and_stop();
	end
	initial begin
		repeat (6000) @(posedge pclk);
		errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire

/* File: src/stp_gate_pkg.sv */
// constants shared by the spanning tree gating block
package stp_gate_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] PORT_CTRL_BASE = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h40;
	localparam logic [7:0] FLUSH_OFS = 8'h44;
	// ----------------------------------------------------------------
	// port control fields
	// ----------------------------------------------------------------
	localparam int TX_PERMIT_BIT = 0;
	localparam int RX_PERMIT_BIT = 1;
	localparam int LEARN_INHIBIT_BIT = 2;
	localparam int TAIL_TAG_EN_BIT = 3;
	localparam int STATE_LSB = 4;
	localparam int CTRL_W = 4;
	// reset into forwarding with tail tagging off
	localparam logic [3:0] PORT_CTRL_RESET = 4'h3;
	// ----------------------------------------------------------------
	// status fields
	// ----------------------------------------------------------------
	localparam int HOST_VALID_BIT = 8;
	localparam int HOST_IDX_LSB = 9;
	localparam int HOST_MULTI_BIT = 12;
	localparam int FLUSH_BUSY_BIT = 13;
	// ----------------------------------------------------------------
	// flush command fields
	// ----------------------------------------------------------------
	localparam int FLUSH_DYN_BIT = 16;
	localparam int FLUSH_STATIC_BIT = 17;
	// ----------------------------------------------------------------
	// decoded port state codes
	// ----------------------------------------------------------------
	localparam logic [1:0] ST_DISCARDING = 2'h0;
	localparam logic [1:0] ST_LEARNING = 2'h1;
	localparam logic [1:0] ST_FORWARDING = 2'h2;
	localparam logic [1:0] ST_OTHER = 2'h3;
endpackage

/* File: src/stp_host_select.sv */
// finds the single tail-tagged port that serves as host
`timescale 1ns/10ps
`default_nettype none
module stp_host_select #(
	parameter int NUM_PORTS = 7
) (
	input wire logic [NUM_PORTS-1:0] tail_en,
	output logic host_valid,
	output logic multi,
	output logic [2:0] host_idx,
	output logic [NUM_PORTS-1:0] host_onehot
);
	logic [3:0] count;
	always_comb begin
		count = 4'h0;
		host_idx = 3'h0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (tail_en[i]) begin
				count = count + 4'h1;
				host_idx = 3'(i);
			end
		end
	end
	// two or more tail-tagged ports leave no host at all
	assign host_valid = (count == 4'h1);
	assign multi = (count > 4'h1);
	assign host_onehot = host_valid ? tail_en : '0;
endmodule
`default_nettype wire

/* File: src/stp_port_gate.sv */
// per-port permit decode from transmit, receive and learning controls
`timescale 1ns/10ps
`default_nettype none
module stp_port_gate
	import stp_gate_pkg::*;
(
	input wire logic tx_permit,
	input wire logic rx_permit,
	input wire logic learn_inhibit,
	input wire logic is_host,
	output logic tx_ok,
	output logic rx_ok,
	output logic learn_ok,
	output logic [1:0] state
);
	// the host port ignores its own state controls
	assign tx_ok = is_host | tx_permit;
	assign rx_ok = is_host | rx_permit;
	assign learn_ok = is_host | ~learn_inhibit;
	always_comb begin
		case ({tx_permit, rx_permit, learn_inhibit})
			3'b001: state = ST_DISCARDING;
			3'b000: state = ST_LEARNING;
			3'b110: state = ST_FORWARDING;
			default: state = ST_OTHER;
		endcase
	end
endmodule
`default_nettype wire

/* File: src/stp_state_gating.sv */
// spanning tree state gating of forwarding, learning and flush per port
`timescale 1ns/10ps
`default_nettype none
module stp_state_gating
	import stp_gate_pkg::*;
#(
	parameter int NUM_PORTS = 7
) (
	input wire logic pclk,
	input wire logic presetn,
	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// ----------------------------------------------------------------
	// forwarding decision request from the fabric
	// ----------------------------------------------------------------
	input wire logic dec_valid,
	input wire logic [2:0] dec_src_port,
	input wire logic [NUM_PORTS-1:0] dec_dst_mask,
	input wire logic dec_override_hit,
	input wire logic dec_tag_lookup,
	input wire logic dec_tag_block_override,
	input wire logic [NUM_PORTS-1:0] dec_tag_mask,
	output logic res_valid,
	output logic [NUM_PORTS-1:0] res_mask,
	output logic res_learn,
	// ----------------------------------------------------------------
	// table flush request to the lookup engine
	// ----------------------------------------------------------------
	output logic flush_valid,
	input wire logic flush_ready,
	output logic [NUM_PORTS-1:0] flush_mask,
	output logic flush_dynamic,
	output logic flush_static
);
	// the port index travels in three bits, so eight ports is the ceiling;
	// a single port would leave nothing for the host to talk to
	if (NUM_PORTS < 2 || NUM_PORTS > 8) begin : g_bad_ports
		$error("NUM_PORTS must lie between 2 and 8");
	end

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic port_hit(input logic [7:0] addr);
		port_hit = (addr[1:0] == 2'b00) && (addr >= PORT_CTRL_BASE)
			&& (addr < PORT_CTRL_BASE + 8'(4 * NUM_PORTS));
	endfunction

	function automatic logic [2:0] port_index(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - PORT_CTRL_BASE;
		port_index = rel[4:2];
	endfunction

	logic access;
	logic wr_en;
	logic addr_ok;
	assign access = psel & penable;
	assign wr_en = access & pwrite;
	assign addr_ok = port_hit(paddr) || paddr == STATUS_OFS || paddr == FLUSH_OFS;
	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = access & ~addr_ok;

	// ----------------------------------------------------------------
	// per-port controls
	// ----------------------------------------------------------------
	logic [NUM_PORTS-1:0] tx_permit_q;
	logic [NUM_PORTS-1:0] rx_permit_q;
	logic [NUM_PORTS-1:0] learn_inhibit_q;
	logic [NUM_PORTS-1:0] tail_en_q;
	logic [NUM_PORTS-1:0] tx_ok;
	logic [NUM_PORTS-1:0] rx_ok;
	logic [NUM_PORTS-1:0] learn_ok;
	logic [1:0] port_state [NUM_PORTS];
	logic host_valid;
	logic host_multi;
	logic [2:0] host_idx;
	logic [NUM_PORTS-1:0] host_onehot;

	// the host port keeps its stored controls, they simply stop mattering
	// to forwarding and learning while its tail tag is the only one set
	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_port
			// a write to one port's word touches only that port
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tx_permit_q[g] <= PORT_CTRL_RESET[TX_PERMIT_BIT];
					rx_permit_q[g] <= PORT_CTRL_RESET[RX_PERMIT_BIT];
					learn_inhibit_q[g] <= PORT_CTRL_RESET[LEARN_INHIBIT_BIT];
					tail_en_q[g] <= PORT_CTRL_RESET[TAIL_TAG_EN_BIT];
				end else if (wr_en && port_hit(paddr) && port_index(paddr) == 3'(g)) begin
					tx_permit_q[g] <= pwdata[TX_PERMIT_BIT];
					rx_permit_q[g] <= pwdata[RX_PERMIT_BIT];
					learn_inhibit_q[g] <= pwdata[LEARN_INHIBIT_BIT];
					tail_en_q[g] <= pwdata[TAIL_TAG_EN_BIT];
				end
			end

			stp_port_gate u_gate (
				.tx_permit(tx_permit_q[g]),
				.rx_permit(rx_permit_q[g]),
				.learn_inhibit(learn_inhibit_q[g]),
				.is_host(host_onehot[g]),
				.tx_ok(tx_ok[g]),
				.rx_ok(rx_ok[g]),
				.learn_ok(learn_ok[g]),
				.state(port_state[g])
			);
		end
	endgenerate

	stp_host_select #(
		.NUM_PORTS(NUM_PORTS)
	) u_host (
		.tail_en(tail_en_q),
		.host_valid(host_valid),
		.multi(host_multi),
		.host_idx(host_idx),
		.host_onehot(host_onehot)
	);

	// ----------------------------------------------------------------
	// forwarding decision
	// ----------------------------------------------------------------
	logic src_ok;
	logic src_is_host;
	logic [NUM_PORTS-1:0] mask_d;
	logic learn_d;

	// compared at four bits so that eight ports does not wrap to zero
	assign src_ok = ({1'b0, dec_src_port} < 4'(NUM_PORTS));
	assign src_is_host = host_valid && dec_src_port == host_idx;

	// host traffic follows its tail tag; other ingress is gated by its own
	// receive permit, and egress by that port's transmit permit except for a directed host frame with block override
	always_comb begin
		mask_d = '0;
		learn_d = 1'b0;
		if (src_ok) begin
			learn_d = learn_ok[dec_src_port];
			if (src_is_host) begin
				if (!dec_tag_lookup && dec_tag_block_override) begin
					// directed host frame overrides port blocking
					mask_d = dec_tag_mask;
				end else if (!dec_tag_lookup) begin
					mask_d = dec_tag_mask & tx_ok;
				end else begin
					mask_d = dec_dst_mask & tx_ok;
				end
			end else if (rx_ok[dec_src_port]) begin
				// normal traffic only reaches ports that may transmit
				mask_d = dec_dst_mask & tx_ok;
			end else if (dec_override_hit) begin
				// blocked ingress reaches only the host, via override entries
				mask_d = dec_dst_mask & host_onehot;
			end
			// never reflect a frame back out of its own ingress port
			mask_d[dec_src_port] = 1'b0;
		end
	end

	// the result lags its request by exactly one edge, back to back allowed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_valid <= 1'b0;
		end else begin
			res_valid <= dec_valid;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_mask <= '0;
			res_learn <= 1'b0;
		end else if (dec_valid) begin
			res_mask <= mask_d;
			res_learn <= learn_d;
		end
	end

	// ----------------------------------------------------------------
	// rapid flush of inhibited ports' entries
	// ----------------------------------------------------------------
	// a flush request is trimmed to ports with learn inhibit set, so a
	// stale command cannot wipe a port that has resumed learning
	logic flush_req;
	logic [NUM_PORTS-1:0] flush_ports;
	assign flush_req = wr_en && paddr == FLUSH_OFS;
	assign flush_ports = pwdata[NUM_PORTS-1:0] & learn_inhibit_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flush_valid <= 1'b0;
		end else if (flush_valid && flush_ready) begin
			flush_valid <= 1'b0;
		end else if (flush_req && !flush_valid && flush_ports != '0) begin
			flush_valid <= 1'b1;
		end
	end

	// a refused request still records its fields while idle, so software
	// can read back what it last asked for
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flush_mask <= '0;
			flush_dynamic <= 1'b0;
			flush_static <= 1'b0;
		end else if (flush_req && !flush_valid) begin
			flush_mask <= flush_ports;
			flush_dynamic <= pwdata[FLUSH_DYN_BIT];
			flush_static <= pwdata[FLUSH_STATIC_BIT];
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// each word is built on its own so the address mux stays a plain
	// select; unmapped addresses read as zero
	logic [31:0] rdata_d;
	logic [31:0] port_word;
	logic [31:0] status_word;
	logic [31:0] flush_word;
	logic [2:0] rd_idx;
	assign rd_idx = port_index(paddr);

	always_comb begin
		port_word = 32'h0000_0000;
		port_word[TX_PERMIT_BIT] = tx_permit_q[rd_idx];
		port_word[RX_PERMIT_BIT] = rx_permit_q[rd_idx];
		port_word[LEARN_INHIBIT_BIT] = learn_inhibit_q[rd_idx];
		port_word[TAIL_TAG_EN_BIT] = tail_en_q[rd_idx];
		port_word[STATE_LSB +: 2] = port_state[rd_idx];
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[NUM_PORTS-1:0] = learn_inhibit_q;
		status_word[HOST_VALID_BIT] = host_valid;
		status_word[HOST_IDX_LSB +: 3] = host_idx;
		status_word[HOST_MULTI_BIT] = host_multi;
		status_word[FLUSH_BUSY_BIT] = flush_valid;
	end

	always_comb begin
		flush_word = 32'h0000_0000;
		flush_word[NUM_PORTS-1:0] = flush_mask;
		flush_word[FLUSH_DYN_BIT] = flush_dynamic;
		flush_word[FLUSH_STATIC_BIT] = flush_static;
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (port_hit(paddr)) begin
			rdata_d = port_word;
		end else if (paddr == STATUS_OFS) begin
			rdata_d = status_word;
		end else if (paddr == FLUSH_OFS) begin
			rdata_d = flush_word;
		end
	end

	// registered during setup so the data stand through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdata_d;
		end
	end
endmodule
`default_nettype wire
